/* File: common/bsm_pkg.sv */
// Purpose: constants, types and setting tables for the button/menu block
// Assumes: 40 MHz system clock, one asynchronous active-high reset
// Notes: times are in ms; the top module turns them into cycle counts
// How it works
// - A single UP or DOWN press at home shows the set point.
// - Further UP/DOWN presses step the set point by one degree.
// - Holding UP or DOWN in set point view keeps stepping.
// - Five idle seconds return home and store the set point on the same edge.
// - The set point always stays between the low and high bounds.
// - Set point stepping ignores whether a display is present.
// - Override press at home or in set point view flashes the snowflake.
// - Menu entry needs the enable switch on and a display present.
// - UP and DOWN held together three seconds in set point view opens the menu.
// - UP and DOWN scroll the menu list circularly.
// - Chord held half a second on an item enters edit, shows SET.
// - Chord held half a second in edit stores the value, back to list.
// - Thirty idle seconds in the menu return home.
// - DOWN alone held half a second in the menu exits home.
// - Menu items follow the fixed order; humidity trim only on humidity variant.
// - Layout picks one of eight; humidity layouts need the humidity variant.
// - Scale choice selects US customary or SI display units.
// - Low bound defaults 20, ranges 0 to high bound, 1 degree steps.
// - A stored low bound above the set point raises the set point.
// - High bound defaults 35, ranges low bound to 50, 1 degree steps.
// - A stored high bound below the set point lowers the set point.
// - Background CO2 reference is held between 200 and 9999 ppm.
// - The menu enable switch allows menu access when on only.
package bsm_pkg;
   typedef enum logic [3:0] {
      ST_HOME = 4'h1,
      ST_SETPT = 4'h2,
      ST_MENU = 4'h4,
      ST_EDIT = 4'h8
   } bsm_state_t;
   typedef logic signed [15:0] bsm_val_t;
   typedef struct packed {
      logic wr;
      logic [3:0] item;
      bsm_val_t data;
   } bsm_nvm_t;
   typedef struct packed {
      bsm_state_t screen;
      logic [3:0] item;
      bsm_val_t value;
      logic set_word;
      logic snow;
   } bsm_disp_t;
   localparam int unsigned CLK_KHZ = 40000;
   localparam int unsigned SP_TO_MS = 5000;
   localparam int unsigned MENU_TO_MS = 30000;
   localparam int unsigned ENTRY_MS = 3000;
   localparam int unsigned HOLD_MS = 500;
   localparam int unsigned DB_MS = 20;
   localparam int unsigned REP_MS = 250;
   localparam int unsigned SNOW_MS = 1000;
   localparam int NITEM = 14;
   localparam logic [3:0] IT_LAYOUT = 4'h0;
   localparam logic [3:0] IT_SCALE = 4'h1;
   localparam logic [3:0] IT_LOW = 4'h2;
   localparam logic [3:0] IT_HIGH = 4'h3;
   localparam logic [3:0] IT_HUM = 4'h6;
   localparam logic [3:0] IT_RESTORE = 4'hD;
   localparam logic [3:0] IT_BGREF = 4'hE;
   localparam logic [3:0] IT_SETPT = 4'hF;
   // items: layout, scale, low, high, pressure, gas cal, humidity trim,
   // temp offset, co2 trim, autodetect, line rate, check bit, stop, restore
   localparam bsm_val_t MIN_T [NITEM] = '{16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h02A5, 16'h0000, 16'hFED4, 16'hFED4, 16'hFE0C,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam bsm_val_t MAX_T [NITEM] = '{16'h0007, 16'h0001, 16'h0032,
      16'h0032, 16'h03F8, 16'h0000, 16'h012C, 16'h012C, 16'h01F4,
      16'h0001, 16'h0005, 16'h0002, 16'h0001, 16'h0001};
   localparam bsm_val_t DEF_T [NITEM] = '{16'h0001, 16'h0001, 16'h0014,
      16'h0023, 16'h03F5, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
   localparam bsm_val_t SP_DEF = 16'h0016;
   localparam bsm_val_t BG_MIN = 16'h00C8;
   localparam bsm_val_t BG_MAX = 16'h270F;
   localparam bsm_val_t BG_DEF = 16'h0190;
   // word addresses on the register bus
   localparam logic [4:0] A_SETPT = 5'h00;
   localparam logic [4:0] A_STATUS = 5'h01;
   localparam logic [4:0] A_BGREF = 5'h02;
   localparam logic [4:0] A_CFG = 5'h10;
endpackage

/* File: sim/bsm_operator.sv */
// Purpose: model of the person pressing the three front-panel buttons
// Assumes: buttons change only right after a rising clock edge
// Notes: each release gap outlasts the debounce window so no tap is lost
`timescale 1ns/1ps
`default_nettype none
module bsm_operator (
   input wire logic i_clk,
   output logic o_up,
   output logic o_down,
   output logic o_ovr
);
   initial begin
      o_up = 1'b0;
      o_down = 1'b0;
      o_ovr = 1'b0;
   end
   task automatic drive(input logic u, input logic d, input logic v);
      @(posedge i_clk);
      o_up <= u;
      o_down <= d;
      o_ovr <= v;
   endtask
   // a 12 cycle gap clears the debounce filter between taps
   task automatic tap(input logic u, input logic d, input logic v,
         input int n);
      drive(u, d, v);
      repeat (n) @(posedge i_clk);
      drive(1'b0, 1'b0, 1'b0);
      repeat (12) @(posedge i_clk);
   endtask
endmodule // bsm_operator
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for the button and setup menu block
// Assumes: shortened hold and timeout counts set at the instance
// Notes: set point is reloaded over the bus at the start of the set point, blocked and menu tests
`timescale 1ns/1ps
`default_nettype none
module tb_top import bsm_pkg::*;;
   logic i_clk, i_rst, up, dn, ovr, men, dsp, hum, rd, wr, wrq;
   logic [4:0] adr;
   logic [31:0] wd, rdata, r;
   bsm_disp_t disp;
   bsm_nvm_t nvm, nvm_q;
   logic ovp;
   int err_count, checks, cyc, ovr_n;
   // snowflake keeps its full length, so it still stands for the status read
   bsm_ui #(.P_SP_TO(32'h64), .P_MENU_TO(32'hC8), .P_ENTRY(32'h3C),
      .P_HOLD(32'h1E), .P_DB(32'h4), .P_REP(32'h14)) uut (
      .i_clk(i_clk), .i_rst(i_rst), .i_btn_up(up), .i_btn_down(dn),
      .i_btn_ovr(ovr), .i_menu_en(men), .i_disp_present(dsp),
      .i_has_humidity(hum), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wrq), .o_disp(disp), .o_nvm(nvm),
      .o_ovr_pulse(ovp));
   bsm_operator op (.i_clk(i_clk), .o_up(up), .o_down(dn), .o_ovr(ovr));
   initial i_clk = 1'b0;
   always #12.5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (o_nvm_seen()) nvm_q <= nvm;
      if (ovp === 1'b1) ovr_n <= ovr_n + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         tally_and_finish();
      end
   end
   function automatic logic o_nvm_seen();
      return nvm.wr === 1'b1;
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // request stays up until waitrequest is sampled low at an edge
   // only the cycle ceiling ends a wait that never sees waitrequest low
   task automatic bus(input logic w, input logic [4:0] a,
         input logic [31:0] d);
      @(posedge i_clk);
      adr <= a;
      wd <= d;
      rd <= ~w;
      wr <= w;
      do begin
         @(posedge i_clk);
      end while (wrq !== 1'b0);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk(r, e);
   endtask
   task automatic wait_scr(input bsm_state_t s, input int max);
      for (int i = 0; i < max && disp.screen !== s; i++) @(posedge i_clk);
      chk({28'h0000000, disp.screen}, {28'h0000000, s});
   endtask
   task automatic val(input logic [15:0] e);
      chk({16'h0000, disp.value}, {16'h0000, e});
   endtask
   // home press only enters the view; the chord is built UP first
   task automatic enter_menu();
      op.drive(1'b1, 1'b0, 1'b0);
      repeat (8) @(posedge i_clk);
      op.drive(1'b1, 1'b1, 1'b0);
      wait_scr(ST_MENU, 150);
      op.drive(1'b0, 1'b0, 1'b0);
      repeat (12) @(posedge i_clk);
   endtask
   task automatic t_defaults();
      rdchk(A_SETPT, 32'h00000016);
      rdchk(A_BGREF, 32'h00000190);
      rdchk(A_CFG + 5'h02, 32'h00000014);
      rdchk(A_CFG + 5'h03, 32'h00000023);
      rdchk(5'h08, 32'h00000000);
      bus(1'b1, A_SETPT, 32'h00000064);
      rdchk(A_SETPT, 32'h00000023);
      bus(1'b1, A_SETPT, 32'hFFFFFFFB);
      rdchk(A_SETPT, 32'h00000014);
      bus(1'b1, A_BGREF, 32'h00000064);
      rdchk(A_BGREF, 32'h000000C8);
      bus(1'b1, A_BGREF, 32'h00002710);
      rdchk(A_BGREF, 32'h0000270F);
   endtask
   task automatic t_setpoint();
      bus(1'b1, A_SETPT, 32'h00000016);
      op.tap(1'b0, 1'b1, 1'b0, 8);
      chk({28'h0000000, disp.screen}, {28'h0000000, ST_SETPT});
      val(16'h0016);
      op.tap(1'b1, 1'b0, 1'b0, 8);
      val(16'h0017);
      op.tap(1'b0, 1'b1, 1'b0, 8);
      val(16'h0016);
      op.tap(1'b1, 1'b0, 1'b0, 70);
      val(16'h001A);
      bus(1'b1, A_SETPT, 32'h00000021);
      op.tap(1'b1, 1'b0, 1'b0, 70);
      val(16'h0023);
      wait_scr(ST_HOME, 120);
      repeat (3) @(posedge i_clk);
      chk({12'h000, nvm_q.item, nvm_q.data}, 32'h000F0023);
   endtask
   task automatic t_override();
      int n;
      n = ovr_n;
      op.drive(1'b0, 1'b0, 1'b1);
      repeat (8) @(posedge i_clk);
      chk({31'h00000000, disp.snow}, 32'h00000001);
      rdchk(A_STATUS, 32'h00000110);
      op.tap(1'b0, 1'b0, 1'b0, 12);
      chk(ovr_n, n + 1);
   endtask
   // chord held past entry time must not open the menu
   task automatic t_blocked(input logic e, input logic p);
      men <= e;
      dsp <= p;
      bus(1'b1, A_SETPT, 32'h00000016);
      op.tap(1'b1, 1'b0, 1'b0, 8);
      op.tap(1'b1, 1'b0, 1'b0, 8);
      rdchk(A_SETPT, 32'h00000017);
      op.drive(1'b1, 1'b1, 1'b0);
      repeat (80) @(posedge i_clk);
      chk({31'h00000000, disp.screen === ST_MENU}, 32'h0);
      op.tap(1'b0, 1'b0, 1'b0, 8);
      wait_scr(ST_HOME, 150);
      men <= 1'b1;
      dsp <= 1'b1;
   endtask
   task automatic edit(input int n, input logic u, input logic [15:0] e0,
         input logic [15:0] e1);
      op.tap(1'b1, 1'b1, 1'b0, 42);
      chk({27'h0000000, disp.set_word, disp.screen}, 32'h00000018);
      val(e0);
      repeat (n) op.tap(u, ~u, 1'b0, 8);
      val(e1);
      op.tap(1'b1, 1'b1, 1'b0, 42);
      chk({28'h0000000, disp.screen}, {28'h0000000, ST_MENU});
      chk({16'h0000, nvm_q.data}, {16'h0000, e1});
   endtask
   task automatic t_menu();
      bus(1'b1, A_SETPT, 32'h00000016);
      enter_menu();
      for (int i = 0; i < 14 && disp.item !== 4'hD; i++) begin
         op.tap(1'b1, 1'b0, 1'b0, 8);
      end
      op.tap(1'b1, 1'b0, 1'b0, 8);
      chk({28'h0000000, disp.item}, 32'h00000000);
      op.tap(1'b0, 1'b1, 1'b0, 8);
      chk({28'h0000000, disp.item}, 32'h0000000D);
      repeat (3) op.tap(1'b1, 1'b0, 1'b0, 8);
      edit(4, 1'b1, 16'h0014, 16'h0018);
      rdchk(A_SETPT, 32'h00000018);
      bus(1'b1, A_SETPT, 32'h0000001E);
      op.tap(1'b1, 1'b0, 1'b0, 8);
      edit(7, 1'b0, 16'h0023, 16'h001C);
      rdchk(A_SETPT, 32'h0000001C);
      // let go before a repeat tick at home would reopen the set point view
      op.tap(1'b0, 1'b1, 1'b0, 35);
      chk({28'h0000000, disp.screen}, {28'h0000000, ST_HOME});
   endtask
   // menu reopens on the scale item left by the down-hold exit above
   task automatic t_menu_timeout();
      hum <= 1'b0;
      enter_menu();
      edit(2, 1'b0, 16'h0001, 16'h0000);
      repeat (5) op.tap(1'b1, 1'b0, 1'b0, 8);
      chk({28'h0000000, disp.item}, 32'h00000007);
      op.tap(1'b0, 1'b1, 1'b0, 8);
      chk({28'h0000000, disp.item}, 32'h00000005);
      repeat (150) @(posedge i_clk);
      chk({28'h0000000, disp.screen}, {28'h0000000, ST_MENU});
      wait_scr(ST_HOME, 100);
      hum <= 1'b1;
   endtask
   initial begin
      i_rst = 1'b1;
      men = 1'b1;
      dsp = 1'b1;
      hum = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      adr = 5'h00;
      wd = 32'h00000000;
      err_count = 0;
      checks = 0;
      cyc = 0;
      ovr_n = 0;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      t_defaults();
      t_setpoint();
      t_override();
      t_blocked(1'b1, 1'b0);
      t_blocked(1'b0, 1'b1);
      t_menu();
      t_menu_timeout();
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire

/* File: src/bsm_ui.sv */
// Purpose: front-panel buttons, set point and setup menu controller
// Assumes: button and switch inputs synchronous to i_clk, high = pressed
// Notes: display and nvm outputs trail the internal state by one cycle
`timescale 1ns/1ps
`default_nettype none
module bsm_ui import bsm_pkg::*; #(
   parameter logic [31:0] P_SP_TO = CLK_KHZ * SP_TO_MS,
   parameter logic [31:0] P_MENU_TO = CLK_KHZ * MENU_TO_MS,
   parameter logic [31:0] P_ENTRY = CLK_KHZ * ENTRY_MS,
   parameter logic [31:0] P_HOLD = CLK_KHZ * HOLD_MS,
   parameter logic [31:0] P_DB = CLK_KHZ * DB_MS,
   parameter logic [31:0] P_REP = CLK_KHZ * REP_MS,
   parameter logic [31:0] P_SNOW = CLK_KHZ * SNOW_MS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_btn_up,
   input wire logic i_btn_down,
   input wire logic i_btn_ovr,
   input wire logic i_menu_en,
   input wire logic i_disp_present,
   input wire logic i_has_humidity,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output bsm_disp_t o_disp,
   output bsm_nvm_t o_nvm,
   output logic o_ovr_pulse
);
   function automatic bsm_val_t stepv(bsm_val_t v, logic up, bsm_val_t lo,
                                      bsm_val_t hi);
      if (up) return (v >= hi) ? hi : bsm_val_t'(v + 16'sh0001);
      return (v <= lo) ? lo : bsm_val_t'(v - 16'sh0001);
   endfunction

   function automatic logic hum_lay(bsm_val_t v);
      return v == 16'sh0000 || v == 16'sh0002 || v == 16'sh0006;
   endfunction

   function automatic logic [3:0] nxt(logic [3:0] it, logic up, logic hum);
      logic [3:0] n;
      if (up) n = (it == IT_RESTORE) ? IT_LAYOUT : 4'(it + 4'h1);
      else n = (it == IT_LAYOUT) ? IT_RESTORE : 4'(it - 4'h1);
      if (n == IT_HUM && !hum) n = up ? 4'(n + 4'h1) : 4'(n - 4'h1);
      return n;
   endfunction

   function automatic logic [31:0] ext(bsm_val_t v);
      return {{16{v[15]}}, v};
   endfunction

   bsm_state_t state, next_state;
   logic [2:0] raw, btn, btn_q;
   logic [1:0] pat, pat_q;
   logic [31:0] hold_cnt, rep_cnt, idle_cnt, snow_cnt;
   logic fired, ack;
   logic [3:0] item;
   bsm_val_t sp, edit_val, bgref;
   bsm_val_t cfg [NITEM];

   // debounce: a level must stay changed for P_DB cycles to be taken
   assign raw = {i_btn_ovr, i_btn_down, i_btn_up};
   for (genvar g = 0; g < 3; g++) begin : g_db
      logic [31:0] cnt;
      logic lvl;
      always_ff @(posedge i_clk or posedge i_rst) begin
         if (i_rst) begin
            cnt <= '0;
            lvl <= 1'b0;
         end else if (raw[g] == lvl) begin
            cnt <= '0;
         end else if (cnt == P_DB - 32'h1) begin
            cnt <= '0;
            lvl <= raw[g];
         end else begin
            cnt <= cnt + 32'h1;
         end
      end
      assign btn[g] = lvl;
   end

   wire up = btn[0];
   wire dn = btn[1];
   wire up_rise = btn[0] & ~btn_q[0];
   wire dn_rise = btn[1] & ~btn_q[1];
   wire ov_rise = btn[2] & ~btn_q[2];
   wire any_edge = |(btn ^ btn_q);
   assign pat = {up, dn};
   assign pat_q = {btn_q[0], btn_q[1]};
   wire pat_same = pat == pat_q;
   wire single = pat == 2'b10 || pat == 2'b01;
   wire rep_tick = single && pat_same && rep_cnt == P_REP - 32'h1;
   wire step_up = (up_rise & ~dn) | (rep_tick & up);
   wire step_dn = (dn_rise & ~up) | (rep_tick & dn);
   wire at_home = state == ST_HOME || state == ST_SETPT;
   wire [31:0] chord_thr = at_home ? P_ENTRY : P_HOLD;
   wire chord_fire = pat == 2'b11 && pat_same && !fired &&
                     hold_cnt == chord_thr - 32'h1;
   wire down_fire = pat == 2'b01 && pat_same && !fired &&
                    state == ST_MENU && hold_cnt == P_HOLD - 32'h1;
   wire entry_ok = i_menu_en & i_disp_present;
   wire [31:0] to_thr = (state == ST_SETPT) ? P_SP_TO : P_MENU_TO;
   wire timeout = state != ST_HOME && !any_edge &&
                  idle_cnt == to_thr - 32'h1;

   // edit limits: the two bounds limit each other
   wire bsm_val_t lo_lim = (item == IT_HIGH) ? cfg[IT_LOW] : MIN_T[item];
   wire bsm_val_t hi_lim = (item == IT_LOW) ? cfg[IT_HIGH] : MAX_T[item];
   wire bsm_val_t ed_a = stepv(edit_val, step_up, lo_lim, hi_lim);
   wire bsm_val_t ed_b = stepv(ed_a, step_up, lo_lim, hi_lim);
   // layouts showing humidity are skipped on the plain variant
   wire lay_fix = item == IT_LAYOUT && !i_has_humidity && hum_lay(ed_a);
   wire bsm_val_t ed_next = !lay_fix ? ed_a :
                            hum_lay(ed_b) ? edit_val : ed_b;
   wire bsm_val_t sp_next =
      stepv(sp, step_up, cfg[IT_LOW], cfg[IT_HIGH]);
   wire save = state == ST_EDIT && chord_fire;
   wire sp_step = state == ST_SETPT && next_state == ST_SETPT &&
                  (step_up | step_dn);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_HOME: begin
            if (step_up | step_dn) next_state = ST_SETPT;
         end
         ST_SETPT: begin
            if (chord_fire && entry_ok) next_state = ST_MENU;
            else if (timeout) next_state = ST_HOME;
         end
         ST_MENU: begin
            if (timeout || down_fire) next_state = ST_HOME;
            else if (chord_fire) next_state = ST_EDIT;
         end
         ST_EDIT: begin
            if (timeout) next_state = ST_HOME;
            else if (chord_fire) next_state = ST_MENU;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_HOME;
         btn_q <= '0;
         fired <= 1'b0;
      end else begin
         state <= next_state;
         btn_q <= btn;
         fired <= pat_same & (fired | chord_fire | down_fire);
      end
   end

   // hold, repeat, idle and snowflake timers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         hold_cnt <= '0;
         rep_cnt <= '0;
         idle_cnt <= '0;
         snow_cnt <= '0;
      end else begin
         hold_cnt <= (!pat_same || pat == 2'b00) ? '0 :
                     (&hold_cnt) ? hold_cnt : hold_cnt + 32'h1;
         rep_cnt <= (!single || !pat_same || rep_tick) ? '0 :
                    rep_cnt + 32'h1;
         idle_cnt <= (any_edge || state != next_state) ? '0 :
                     (&idle_cnt) ? idle_cnt : idle_cnt + 32'h1;
         if (ov_rise && at_home) snow_cnt <= P_SNOW - 32'h1;
         else if (snow_cnt != '0) snow_cnt <= snow_cnt - 32'h1;
      end
   end

   // bus slave: every access sees exactly one wait cycle
   wire req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack;
   wire wr_go = i_avs_write & ack;
   wire cfg_hit = i_avs_address[4] && i_avs_address[3:0] <= IT_RESTORE;
   wire bsm_val_t wv = i_avs_writedata[15:0];
   wire wv_ok = i_avs_writedata[31:16] == {16{wv[15]}};
   wire bsm_val_t wv_sp = !wv_ok ? sp : (wv < cfg[IT_LOW]) ? cfg[IT_LOW] :
                          (wv > cfg[IT_HIGH]) ? cfg[IT_HIGH] : wv;
   wire bsm_val_t wv_bg = (!wv_ok || wv > BG_MAX) ? BG_MAX :
                          (wv < BG_MIN) ? BG_MIN : wv;
   wire [31:0] status_w = {23'h0, snow_cnt != '0, state, item};
   wire [31:0] rd_mux = (i_avs_address == A_SETPT) ? ext(sp) :
                        (i_avs_address == A_STATUS) ? status_w :
                        (i_avs_address == A_BGREF) ? ext(bgref) :
                        cfg_hit ? ext(cfg[i_avs_address[3:0]]) : 32'h0;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ack <= 1'b0;
         o_avs_readdata <= '0;
      end else begin
         ack <= req & ~ack;
         if (i_avs_read && !ack) o_avs_readdata <= rd_mux;
      end
   end

   // menu position and edit buffer
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         item <= IT_LAYOUT;
         edit_val <= '0;
      end else if (state == ST_MENU && next_state == ST_MENU &&
                   (step_up | step_dn)) begin
         item <= nxt(item, step_up, i_has_humidity);
      end else if (state == ST_MENU && next_state == ST_EDIT) begin
         edit_val <= cfg[item];
      end else if (state == ST_EDIT && next_state == ST_EDIT &&
                   (step_up | step_dn)) begin
         edit_val <= ed_next;
      end
   end

   // settings, set point and background reference
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < NITEM; i++) cfg[i] <= DEF_T[i];
         sp <= SP_DEF;
         bgref <= BG_DEF;
      end else if (save && item == IT_RESTORE && edit_val != '0) begin
         for (int i = 0; i < NITEM; i++) cfg[i] <= DEF_T[i];
         sp <= SP_DEF;
         bgref <= BG_DEF;
      end else if (save) begin
         cfg[item] <= edit_val;
         if (item == IT_LOW && edit_val > sp) sp <= edit_val;
         if (item == IT_HIGH && edit_val < sp) sp <= edit_val;
      end else if (sp_step) begin
         sp <= sp_next;
      end else if (wr_go && i_avs_address == A_SETPT) begin
         sp <= wv_sp;
      end else if (wr_go && i_avs_address == A_BGREF) begin
         bgref <= wv_bg;
      end
   end

   // registered outputs
   wire bsm_val_t shown = (state == ST_SETPT) ? sp :
                          (state == ST_EDIT) ? edit_val :
                          (state == ST_MENU) ? cfg[item] : 16'sh0000;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_disp <= '{screen: ST_HOME, item: IT_LAYOUT, value: 16'sh0000,
                     set_word: 1'b0, snow: 1'b0};
         o_nvm <= '{wr: 1'b0, item: IT_LAYOUT, data: 16'sh0000};
         o_ovr_pulse <= 1'b0;
      end else begin
         o_disp <= '{screen: state, item: item, value: shown,
                     set_word: state == ST_EDIT, snow: snow_cnt != '0};
         o_ovr_pulse <= ov_rise & at_home;
         if (state == ST_SETPT && timeout) begin
            o_nvm <= '{wr: 1'b1, item: IT_SETPT, data: sp};
         end else if (save) begin
            o_nvm <= '{wr: 1'b1, item: item, data: edit_val};
         end else begin
            o_nvm.wr <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_save_low;
      state == ST_EDIT && chord_fire && item == IT_LOW && edit_val > sp;
   endsequence
   sequence s_enter;
      state == ST_SETPT && chord_fire && entry_ok;
   endsequence

   sp_range_a: assert property (sp >= cfg[IT_LOW] && sp <= cfg[IT_HIGH])
      else $error("set point outside bounds");
   home_show_a: assert property (state == ST_HOME && up_rise && !dn |=>
      state == ST_SETPT && sp == $past(sp))
      else $error("first press did not just show set point");
   sp_step_a: assert property (sp_step && step_up && sp < cfg[IT_HIGH]
      |=> sp == $past(sp) + 16'sh0001)
      else $error("set point step wrong");
   sp_tout_a: assert property (state == ST_SETPT && timeout |=>
      state == ST_HOME && o_nvm.wr && o_nvm.item == IT_SETPT)
      else $error("set point timeout or store missing");
   snow_show_a: assert property (ov_rise && at_home |-> ##2
      o_disp.snow)
      else $error("snowflake not shown");
   menu_gate_a: assert property (state == ST_SETPT ##1
      state == ST_MENU |-> $past(i_menu_en) && $past(i_disp_present))
      else $error("menu entered while blocked");
   menu_enter_a: assert property (s_enter |=> state == ST_MENU)
      else $error("menu not entered");
   menu_wrap_a: assert property (state == ST_MENU && next_state == ST_MENU
      && step_up && item == IT_RESTORE |=> item == IT_LAYOUT)
      else $error("menu list did not wrap");
   edit_enter_a: assert property (state == ST_MENU && chord_fire && !timeout
      |=> state == ST_EDIT && edit_val == cfg[item] ##1 o_disp.set_word)
      else $error("edit entry wrong");
   edit_save_a: assert property (save && !timeout |=> state == ST_MENU &&
      o_nvm.wr && o_nvm.item == $past(item))
      else $error("edit save wrong");
   menu_tout_a: assert property (state == ST_MENU && timeout |=>
      state == ST_HOME)
      else $error("menu timeout missed");
   menu_exit_a: assert property (down_fire |=> state == ST_HOME)
      else $error("down hold did not exit");
   low_raise_a: assert property (s_save_low |=> sp == $past(edit_val))
      else $error("set point not raised to low bound");
endmodule // bsm_ui
`default_nettype wire
